// *** design/vicc_top.sv ***
`timescale 1ns/1ps
module vicc_top (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        enable,
	input  wire logic        platform_power_ok,
	input  wire logic        vid_serial_clock,
	input  wire logic        vid_serial_data,
	input  wire logic [5:0]  configOneCode,
	input  wire logic [5:0]  configTwoCode,
	input  wire logic        coreFault,
	input  wire logic        nbFault,
	input  wire logic [7:0]  coreCurrent,
	output logic             telemetry_line,
	output logic [7:0]       coreRef,
	output logic [7:0]       nbRef,
	output logic             coreCcm,
	output logic             nbCcm,
	output logic             core_power_good,
	output logic             nb_power_good,
	output logic             transitionDone
);
	////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [3:0]        syncA_q;
	logic [3:0]        syncB_q;
	logic [3:0]        prev_q;
	logic              enS;
	logic              pokS;
	logic              vclkS;
	logic              vdatS;
	logic              enRise;
	logic              pokFall;
	logic              vclkRise;
	logic              vclkFall;
	logic              startEv;
	logic              stopEv;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			syncA_q <= 4'h0;
			syncB_q <= 4'h0;
			prev_q  <= 4'h0;
		end else begin
			syncA_q <= {enable, platform_power_ok,
				vid_serial_clock, vid_serial_data};
			syncB_q <= syncA_q;
			prev_q  <= syncB_q;
		end
	end

	assign enS     = syncB_q[3];
	assign pokS    = syncB_q[2];
	assign vclkS    = syncB_q[1];
	assign vdatS    = syncB_q[0];
	assign enRise   = enS & ~prev_q[3];
	assign pokFall  = ~pokS & prev_q[2];
	assign vclkRise = vclkS & ~prev_q[1];
	assign vclkFall = ~vclkS & prev_q[1];
	// data edges while clock high mark frame boundaries
	assign startEv  = vclkS & prev_q[1] & prev_q[0] & ~vdatS;
	assign stopEv   = vclkS & prev_q[1] & ~prev_q[0] & vdatS;

	////////////////////////////////////////////////////////////////////
	// sequencing
	vicc_pkg::vicc_state_t state_q;
	logic [7:0]        boot_q;
	logic [7:0]        ref_q [2];
	logic [7:0]        tgt_q [2];
	logic              linkOn;
	logic              atBoot;
	logic              atZero;

	assign atBoot = (ref_q[0] == boot_q) && (ref_q[1] == boot_q);
	assign atZero = (ref_q[0] == 8'h00) && (ref_q[1] == 8'h00);
	assign linkOn = pokS && (state_q == vicc_pkg::ST_RUN);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= vicc_pkg::ST_OFF;
		end else begin
			unique case (state_q)
			vicc_pkg::ST_OFF: begin
				if (enRise) begin
					// power ok already high: wrong order
					state_q <= pokS ? vicc_pkg::ST_BLOCK
						: vicc_pkg::ST_SOFT;
				end
			end
			vicc_pkg::ST_SOFT: begin
				if (!enS)
					state_q <= vicc_pkg::ST_SHUT;
				else if (atBoot)
					state_q <= vicc_pkg::ST_RUN;
			end
			vicc_pkg::ST_RUN: begin
				if (!enS)
					state_q <= vicc_pkg::ST_SHUT;
			end
			vicc_pkg::ST_SHUT: begin
				if (atZero)
					state_q <= vicc_pkg::ST_OFF;
			end
			vicc_pkg::ST_BLOCK: begin
				if (!enS)
					state_q <= vicc_pkg::ST_OFF;
			end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			boot_q <= 8'h00;
		else if (enRise && state_q == vicc_pkg::ST_OFF)
			boot_q <= vicc_pkg::BOOT_LVL[{vclkS, vdatS}];
	end

	////////////////////////////////////////////////////////////////////
	// step timebase: one code step per tick
	logic [5:0]        fastCnt_q;
	logic [5:0]        slowCnt_q;
	logic              fastTick;
	logic              slowTick;
	logic              tick;

	assign fastTick = fastCnt_q == 6'(vicc_pkg::FAST_CYC - 1);
	assign slowTick = slowCnt_q == 6'(vicc_pkg::SLOW_CYC - 1);
	assign tick = (state_q == vicc_pkg::ST_SOFT ||
		state_q == vicc_pkg::ST_SHUT) ? slowTick : fastTick;

	always_ff @(posedge core_clk) begin
		if (rst || fastTick)
			fastCnt_q <= 6'h00;
		else
			fastCnt_q <= fastCnt_q + 6'h01;
	end

	always_ff @(posedge core_clk) begin
		if (rst || slowTick)
			slowCnt_q <= 6'h00;
		else
			slowCnt_q <= slowCnt_q + 6'h01;
	end

	////////////////////////////////////////////////////////////////////
	// packet receiver
	logic [26:0]       pkt_q;
	logic [4:0]        bitCnt_q;
	logic              inPkt_q;
	logic              cmdValid;
	logic [1:0]        sel;
	logic [7:0]        vid;
	logic [7:0]        cmdLvl;
	logic              psiA;
	logic              psiB;
	logic              tlmFnBit;
	logic [4:0]        trim;

	always_ff @(posedge core_clk) begin
		if (rst || !linkOn) begin
			pkt_q    <= 27'h0;
			bitCnt_q <= 5'h00;
			inPkt_q  <= 1'b0;
		end else if (startEv) begin
			bitCnt_q <= 5'h00;
			inPkt_q  <= 1'b1;
		end else if (stopEv) begin
			inPkt_q  <= 1'b0;
		end else if (inPkt_q && vclkRise &&
			bitCnt_q != vicc_pkg::PKT_BITS) begin
			pkt_q    <= {pkt_q[25:0], vdatS};
			bitCnt_q <= bitCnt_q + 5'h01;
		end
	end

	// bit time t sits at pkt_q[27-t]
	assign sel    = {pkt_q[20], pkt_q[21]};
	assign psiA   = pkt_q[17];
	assign vid    = {pkt_q[16:10], pkt_q[8]};
	assign psiB   = pkt_q[7];
	assign tlmFnBit = pkt_q[6];
	assign trim   = pkt_q[5:1];
	// off codes give a zero reference
	assign cmdLvl = (vid >= vicc_pkg::VID_ZERO) ? 8'h00
		: vicc_pkg::VID_ZERO - vid;
	assign cmdValid = linkOn && inPkt_q && stopEv &&
		bitCnt_q == vicc_pkg::PKT_BITS &&
		pkt_q[26:22] == vicc_pkg::PKT_HEADER && !pkt_q[19];

	////////////////////////////////////////////////////////////////////
	// rail references
	logic [1:0]        moving_q;
	logic [1:0]        diode_q;
	logic [1:0]        doneEv;
	logic [1:0]        fault;
	logic [4:0]        trim_q [2];

	assign fault = {nbFault, coreFault};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			for (int r = 0; r < 2; r++) begin
				ref_q[r]  <= 8'h00;
				tgt_q[r]  <= 8'h00;
				trim_q[r] <= 5'h00;
			end
			moving_q <= 2'b00;
			diode_q  <= 2'b00;
		end else begin
			for (int r = 0; r < 2; r++) begin
				if (tick && ref_q[r] < tgt_q[r])
					ref_q[r] <= ref_q[r] + 8'h01;
				else if (tick && ref_q[r] > tgt_q[r])
					ref_q[r] <= ref_q[r] - 8'h01;
				if (state_q == vicc_pkg::ST_OFF && enRise && !pokS) begin
					tgt_q[r]   <= vicc_pkg::BOOT_LVL[{vclkS, vdatS}];
					diode_q[r] <= 1'b0;
				end else if (!enS && state_q != vicc_pkg::ST_OFF) begin
					tgt_q[r]    <= 8'h00;
					moving_q[r] <= 1'b0;
					diode_q[r]  <= 1'b0;
				end else if (pokFall && state_q == vicc_pkg::ST_RUN) begin
					tgt_q[r]    <= boot_q;
					moving_q[r] <= 1'b0;
					diode_q[r]  <= 1'b0;
				end else if (cmdValid && sel[r]) begin
					tgt_q[r]    <= cmdLvl;
					moving_q[r] <= 1'b1;
					diode_q[r]  <= ~psiA;
					trim_q[r]   <= trim;
				end else if (doneEv[r]) begin
					moving_q[r] <= 1'b0;
				end
			end
		end
	end

	always_comb begin
		for (int r = 0; r < 2; r++)
			doneEv[r] = moving_q[r] && ref_q[r] == tgt_q[r] &&
				state_q == vicc_pkg::ST_RUN &&
				!(cmdValid && sel[r]);
	end

	////////////////////////////////////////////////////////////////////
	// power good and mode outputs
	logic [1:0]        pg_q;
	logic              done_q;
	logic [1:0]        ctrl_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pg_q <= 2'b00;
		end else begin
			for (int r = 0; r < 2; r++) begin
				if (state_q == vicc_pkg::ST_SOFT && enS && atBoot)
					pg_q[r] <= ~fault[r];
				else if (state_q != vicc_pkg::ST_RUN || !enS || fault[r])
					pg_q[r] <= 1'b0;
				// no clear on a change or an off code
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			done_q  <= 1'b0;
			coreRef <= 8'h00;
			nbRef   <= 8'h00;
			coreCcm <= 1'b1;
			nbCcm   <= 1'b1;
		end else begin
			done_q  <= |(doneEv & ~fault);
			coreRef <= ref_q[0];
			nbRef   <= ref_q[1];
			// a change always runs in conduction mode
			coreCcm <= ~diode_q[0] | moving_q[0] |
				(state_q != vicc_pkg::ST_RUN);
			nbCcm   <= ~diode_q[1] | moving_q[1] |
				(state_q != vicc_pkg::ST_RUN);
		end
	end

	assign core_power_good = pg_q[0];
	assign nb_power_good   = pg_q[1];
	assign transitionDone  = done_q;

	////////////////////////////////////////////////////////////////////
	// telemetry transmitter
	logic              tlmOn_q;
	logic              tlmCur_q;
	logic              cmpPend_q;
	logic [19:0]       tlmSr_q;
	logic [4:0]        tlmCnt_q;
	logic              tlmLine_q;
	logic [19:0]       frame;
	logic              loadSlot;

	assign loadSlot = linkOn && vclkFall && tlmCnt_q == 5'h00;
	always_comb begin
		if (cmpPend_q)
			frame = vicc_pkg::TLM_DONE;
		else if (tlmOn_q)
			frame = {ref_q[0], 2'b00, tlmCur_q ? coreCurrent
				: ref_q[1], 2'b00};
		else
			frame = 20'hfffff;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tlmOn_q  <= 1'b1;
			tlmCur_q <= 1'b0;
		end else if (cmdValid && tlmFnBit) begin
			tlmOn_q  <= ~(sel[0] & sel[1]);
			tlmCur_q <= sel[1] & ~sel[0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			cmpPend_q <= 1'b0;
		else if (done_q && ctrl_q[0])
			cmpPend_q <= 1'b1; // set beats the slot clear
		else if (loadSlot)
			cmpPend_q <= 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (rst || !linkOn) begin
			tlmSr_q   <= 20'hfffff;
			tlmCnt_q  <= 5'h00;
			tlmLine_q <= 1'b1;
		end else if (loadSlot) begin
			tlmSr_q   <= {frame[18:0], 1'b1};
			tlmCnt_q  <= vicc_pkg::TLM_BITS - 5'h01;
			tlmLine_q <= frame[19];
		end else if (vclkFall) begin
			tlmSr_q   <= {tlmSr_q[18:0], 1'b1};
			tlmCnt_q  <= tlmCnt_q - 5'h01;
			tlmLine_q <= tlmSr_q[19];
		end
	end

	assign telemetry_line = tlmLine_q;

	////////////////////////////////////////////////////////////////////
	// configuration pins, sampled once
	logic [11:0]       cfgA_q;
	logic [11:0]       cfgB_q;
	logic [11:0]       cfg_q;
	logic [2:0]        cfgCnt_q;
	logic              cfgDone_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfgA_q    <= 12'h000;
			cfgB_q    <= 12'h000;
			cfg_q     <= 12'h000;
			cfgCnt_q  <= 3'h0;
			cfgDone_q <= 1'b0;
		end else begin
			cfgA_q <= {configTwoCode, configOneCode};
			cfgB_q <= cfgA_q;
			if (!cfgDone_q) begin
				cfgCnt_q <= cfgCnt_q + 3'h1;
				if (cfgCnt_q == vicc_pkg::CFG_SETTLE) begin
					cfg_q     <= cfgB_q;
					cfgDone_q <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// ahb-lite slave, zero wait states
	logic              wPend_q;
	logic [7:0]        wAddr_q;
	logic [31:0]       rdata_q;
	logic [31:0]       rmux;
	logic              take;

	assign take = hsel && hready && htrans[1];
	always_comb begin
		unique case (haddr[7:0])
		vicc_pkg::OFS_CTRL:   rmux = {30'h0, ctrl_q};
		vicc_pkg::OFS_STATUS: rmux = {7'h0, state_q, moving_q,
			nbCcm, coreCcm, pg_q, ref_q[1], ref_q[0]};
		vicc_pkg::OFS_CMD:    rmux = {11'h0, boot_q, tlmCur_q,
			tlmOn_q, cmpPend_q, trim_q[1], trim_q[0]};
		// fields: limit, comp1, ramp, delay, comp0 | ofs, zll, qr
		vicc_pkg::OFS_CFG:    rmux = {19'h0, cfgDone_q,
			cfg_q[11:10], cfg_q[9], cfg_q[8], cfg_q[7], cfg_q[6],
			cfg_q[5:3], cfg_q[2], cfg_q[1:0]};
		default:              rmux = 32'h0;
		endcase
		if (haddr[31:8] != 24'h0)
			rmux = 32'h0;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wPend_q <= 1'b0;
			wAddr_q <= 8'h00;
			rdata_q <= 32'h0;
			ctrl_q  <= vicc_pkg::CTRL_RESET;
		end else begin
			if (wPend_q && wAddr_q == vicc_pkg::OFS_CTRL)
				ctrl_q <= hwdata[1:0];
			wPend_q <= take && hwrite && haddr[31:8] == 24'h0;
			if (take) begin
				wAddr_q <= haddr[7:0];
				rdata_q <= hwrite ? 32'h0 : rmux;
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;
endmodule : vicc_top

// *** design/vicc_pkg.sv ***
// Function
// - bit times 20..26 carry psi_b, telemetry bit, slope trim, offset trim
// - serial link accepted only while platform_power_ok is high
// - valid command steps each addressed rail, both together if both chosen
// - power ok falling drives telemetry high and sends rails back to boot
// - with power ok low the serial clock and data are read only at enable rise, to latch the boot code
// - power ok rising resumes link, references stay at boot until command
// - power ok must rise after enable, otherwise no soft-start
// - rising target steps reference up at 12.5 mV per us
// - falling target steps reference down at 12.5 mV per us
// - rail forced to continuous conduction during a change, then restored
// - power good stays high during an on-the-fly change
// - at change end check faults, then report transition complete
// - voltage-off code steps reference to zero, power good stays high
// - both rails start in continuous conduction
// - core rail: psi_a low gives diode emulation, high gives conduction
// - northbridge rail uses the same power-state decoding
// - telemetry frame: core voltage, then nb voltage or current
// - config pins decoded once after power-up and held
// - config pin fields: limits, comp bits, ramp, delay, offset, zll, qr
// - boot code latched from link pins at enable rise, cleared at reset
// - bit times 6 and 7 select rails taking the following fields
// - soft-start and soft-shutdown ramp at 3 mV per us
package vicc_pkg;
	localparam int          CLK_NS        = 50;
	localparam int          STEP_UV       = 6250;
	localparam int          FAST_UV_US    = 12500;
	localparam int          SLOW_UV_US    = 3000;
	localparam int          FAST_STEP_NS  = STEP_UV * 1000 / FAST_UV_US;
	localparam int          SLOW_STEP_NS  = STEP_UV * 1000 / SLOW_UV_US;
	localparam int          FAST_CYC      = FAST_STEP_NS / CLK_NS;
	localparam int          SLOW_CYC      = SLOW_STEP_NS / CLK_NS;
	localparam logic [7:0]  VID_ZERO      = 8'hf8;
	localparam logic [4:0]  PKT_BITS      = 5'h1b;
	localparam logic [4:0]  TLM_BITS      = 5'h14;
	localparam logic [4:0]  PKT_HEADER    = 5'h18;
	localparam logic [19:0] TLM_DONE      = 20'h00000;
	localparam logic [2:0]  CFG_SETTLE    = 3'h4;
	localparam logic [7:0]  BOOT_LVL [4]  = '{8'hb0, 8'ha0, 8'h90, 8'h80};
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_CMD       = 8'h08;
	localparam logic [7:0]  OFS_CFG       = 8'h0c;
	localparam logic [1:0]  CTRL_RESET    = 2'h1;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_SOFT,
		ST_RUN,
		ST_SHUT,
		ST_BLOCK
	} vicc_state_t;
endpackage : vicc_pkg

// *** verification/vicc_top_properties.sv ***
`timescale 1ns/1ps
module vicc_top_properties (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       enable,
	input wire logic       platform_power_ok,
	input wire logic       coreFault,
	input wire logic       telemetry_line,
	input wire logic [7:0] coreRef,
	input wire logic [7:0] nbRef,
	input wire logic       coreCcm,
	input wire logic       nbCcm,
	input wire logic       core_power_good,
	input wire logic       transitionDone
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
////////////////////////////////////////
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not zero-wait okay");
	chk_ref_unit: assert property (
		$changed(coreRef) |-> (coreRef - $past(coreRef) == 8'h01 ||
		$past(coreRef) - coreRef == 8'h01))
		else $error("core ref moved more than one step");
	// fastest rate is one step per ten cycles
	chk_step_gap: assert property (
		$changed(coreRef) |=> $stable(coreRef) [*8])
		else $error("core ref stepped too soon");
	chk_core_ccm: assert property (
		$changed(coreRef) |-> coreCcm)
		else $error("core moving outside conduction mode");
	chk_nb_ccm: assert property (
		$changed(nbRef) |-> nbCcm)
		else $error("nb moving outside conduction mode");
	chk_telem_high: assert property (
		!platform_power_ok [*4] |-> telemetry_line)
		else $error("telemetry not high with power ok low");
	chk_done_pulse: assert property (
		transitionDone |=> !transitionDone)
		else $error("completion longer than one cycle");
	chk_done_settled: assert property (
		transitionDone |=> $stable(coreRef) && $stable(nbRef))
		else $error("completion while still moving");
	chk_core_power_good_held: assert property (
		$changed(coreRef) && $past(core_power_good) && enable &&
		!coreFault |-> core_power_good)
		else $error("power good dropped during a change");
	cover property (transitionDone);
	cover property ($fell(platform_power_ok));
	cover property ($changed(coreRef) && $changed(nbRef));
endmodule : vicc_top_properties

bind vicc_top vicc_top_properties vicc_top_properties_inst (
	.core_clk, .rst, .hreadyout, .hresp, .enable, .platform_power_ok,
	.coreFault, .telemetry_line, .coreRef, .nbRef, .coreCcm, .nbCcm,
	.core_power_good, .transitionDone
);

// *** verification/vicc_link_master.sv ***
`timescale 1ns/1ps
module vicc_link_master (
	output logic linkClk,
	output logic linkData
);
	// clock stands high between frames; data idles at its pull-up
	initial begin
		linkClk = 1'b1;
		linkData = 1'b1;
	end
	task automatic setPins(input logic c, input logic d);
		linkClk = c;
		linkData = d;
	endtask : setPins
	// between start and stop, data moves only while the clock is low, so no false start/stop
	task automatic send(input logic [26:0] bits);
		linkData = 1'b0;
		#200 linkClk = 1'b0;
		for (int i = 26; i >= 0; i--) begin
			linkData = bits[i];
			#200 linkClk = 1'b1;
			#200 linkClk = 1'b0;
		end
		linkData = 1'b0;
		#200 linkClk = 1'b1;
		#200 linkData = 1'b1;
		#400;
	endtask : send
endmodule : vicc_link_master

// *** verification/vicc_top_bench.sv ***
`timescale 1ns/1ps
module vicc_top_bench;
	localparam logic [7:0] BOOT = vicc_pkg::BOOT_LVL[2];
	logic        core_clk;
	logic        rst;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        enable;
	logic        platform_power_ok;
	logic        linkClk;
	logic        linkData;
	logic [5:0]  configOneCode;
	logic [5:0]  configTwoCode;
	logic        coreFault;
	logic        nbFault;
	logic [7:0]  coreCurrent;
	logic        telemetry_line;
	logic [7:0]  coreRef;
	logic [7:0]  nbRef;
	logic        coreCcm;
	logic        nbCcm;
	logic        core_power_good;
	logic        nb_power_good;
	logic        transitionDone;
	logic [31:0] seed = 32'h9259c794;
	int          failCount = 0;
	int          samplesChecked = 0;
	int          doneCount = 0;

	vicc_top vicc_top_inst (
		.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .enable,
		.platform_power_ok, .vid_serial_clock(linkClk),
		.vid_serial_data(linkData), .configOneCode, .configTwoCode,
		.coreFault, .nbFault, .coreCurrent, .telemetry_line,
		.coreRef, .nbRef, .coreCcm, .nbCcm, .core_power_good,
		.nb_power_good, .transitionDone
	);
	vicc_link_master vicc_link_master_inst (.linkClk, .linkData);
	// completion pulses counted where they stand, between clock edges
	always @(negedge core_clk)
		if (transitionDone === 1'b1)
			doneCount <= doneCount + 1;
////////////////////////////////////////
	function automatic logic [31:0] nextRnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nextRnd
	// sel is {core, nb}; acks left high as the pull-up would
	function automatic logic [26:0] pkt(input logic [1:0] sel,
		input logic psi, input logic [7:0] vid);
		return {5'b11000, sel, 2'b01, psi, vid[7:1], 1'b1, vid[0],
			2'b10, 5'h00, 1'b1};
	endfunction : pkt
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			failCount++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic testDone;
		$display("checked=%0d failed=%0d", samplesChecked, failCount);
		if (failCount == 0 && samplesChecked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : testDone
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic waitRefs(input logic [7:0] c, input logic [7:0] n);
		for (int k = 0; k < 8000; k++) begin
			@(negedge core_clk);
			if (coreRef === c && nbRef === n) break;
		end
		check({16'h0, coreRef, nbRef}, {16'h0, c, n});
	endtask : waitRefs
////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// two slow ramps of about 6000 cycles each dominate the run
	initial begin
		#3000000;
		failCount++;
		testDone();
	end
	initial begin
		logic [31:0] rd;
		logic [31:0] cfgExp;
		logic [7:0]  tgt [2];
		logic        ccmExp [2];
		logic [1:0]  sel;
		logic [7:0]  lvl;
		int          doneMark;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		enable = 1'b0;
		platform_power_ok = 1'b0;
		coreFault = 1'b0;
		nbFault = 1'b0;
		configOneCode = seed[5:0];
		configTwoCode = seed[11:6];
		coreCurrent = seed[19:12];
		cfgExp = {19'h0, 1'b1, seed[11:6], seed[5:0]};
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		vicc_link_master_inst.setPins(1'b1, 1'b0);
		@(negedge core_clk);
		check({20'h0, coreRef, coreCcm, nbCcm, telemetry_line,
			core_power_good}, 32'he);
		repeat (20) @(posedge core_clk);
		ahb(1'b0, vicc_pkg::OFS_CTRL, 32'h0, rd);
		check(rd, {30'h0, vicc_pkg::CTRL_RESET});
		ahb(1'b0, vicc_pkg::OFS_CFG, 32'h0, rd);
		check(rd, cfgExp);
		configOneCode <= ~configOneCode;
		ahb(1'b0, vicc_pkg::OFS_CFG, 32'h0, rd);
		check(rd, cfgExp);
		enable <= 1'b1;
		repeat (10) @(posedge core_clk);
		vicc_link_master_inst.setPins(1'b1, 1'b1);
		waitRefs(BOOT, BOOT);
		repeat (5) @(negedge core_clk);
		check({30'h0, core_power_good, nb_power_good}, 32'h3);
		// link must stay deaf until power ok rises
		vicc_link_master_inst.send(pkt(2'h3, 1'b1, 8'h68));
		repeat (40) @(negedge core_clk);
		check({24'h0, coreRef}, {24'h0, BOOT});
		@(posedge core_clk);
		platform_power_ok <= 1'b1;
		tgt = '{BOOT, BOOT};
		ccmExp = '{1'b1, 1'b1};
		// a start before power ok clears the synchroniser would be lost
		repeat (10) @(posedge core_clk);
		for (int i = 0; i < 6; i++) begin
			seed = nextRnd(seed);
			coreCurrent <= seed[15:8];
			sel = (seed[1:0] == 2'h0) ? 2'h3 : seed[1:0];
			lvl = (i == 5) ? 8'h00 : {3'h4, seed[6:2]};
			doneMark = doneCount;
			// even packets are not waited on or checked; the next one is sent straight after
			vicc_link_master_inst.send(
				pkt(sel, seed[7], vicc_pkg::VID_ZERO - lvl));
			if (sel[1]) begin
				tgt[0] = lvl;
				ccmExp[0] = seed[7];
			end
			if (sel[0]) begin
				tgt[1] = lvl;
				ccmExp[1] = seed[7];
			end
			if (i[0]) begin
				waitRefs(tgt[0], tgt[1]);
				repeat (5) @(negedge core_clk);
				check({30'h0, coreCcm, nbCcm},
					{30'h0, ccmExp[0], ccmExp[1]});
				check({30'h0, core_power_good, nb_power_good}, 32'h3);
				check({31'h0, doneCount > doneMark}, 32'h1);
			end
		end
		// a fault at completion suppresses the pulse, drops power good
		@(posedge core_clk);
		coreFault <= 1'b1;
		nbFault <= 1'b1;
		doneMark = doneCount;
		vicc_link_master_inst.send(pkt(2'h3, 1'b1,
			vicc_pkg::VID_ZERO - 8'h60));
		waitRefs(8'h60, 8'h60);
		repeat (5) @(negedge core_clk);
		check({29'h0, doneCount != doneMark, core_power_good,
			nb_power_good}, 32'h0);
		@(posedge core_clk);
		coreFault <= 1'b0;
		nbFault <= 1'b0;
		platform_power_ok <= 1'b0;
		repeat (6) @(negedge core_clk);
		check({31'h0, telemetry_line}, 32'h1);
		vicc_link_master_inst.send(pkt(2'h3, 1'b1, 8'h70));
		waitRefs(BOOT, BOOT);
		@(posedge core_clk);
		platform_power_ok <= 1'b1;
		repeat (100) @(negedge core_clk);
		check({24'h0, coreRef}, {24'h0, BOOT});
		@(posedge core_clk);
		ahb(1'b0, vicc_pkg::OFS_STATUS, 32'h0, rd);
		check({16'h0, rd[15:0]}, {16'h0, BOOT, BOOT});
		ahb(1'b0, 8'h40, 32'h0, rd);
		check(rd, 32'h0);
		ahb(1'b1, vicc_pkg::OFS_CTRL, 32'h2, rd);
		ahb(1'b0, vicc_pkg::OFS_CTRL, 32'h0, rd);
		check(rd, 32'h2);
		// soft-shutdown, then enable again with power ok already high
		enable <= 1'b0;
		waitRefs(8'h00, 8'h00);
		repeat (10) @(posedge core_clk);
		enable <= 1'b1;
		repeat (200) @(negedge core_clk);
		check({24'h0, coreRef}, 32'h0);
		@(posedge core_clk);
		ahb(1'b0, vicc_pkg::OFS_STATUS, 32'h0, rd);
		check({29'h0, rd[24:22]}, 32'h4);
		testDone();
	end
endmodule : vicc_top_bench
